// File: svid_master_model.sv
// Purpose: processor-side master issuing register requests on the link
// Assumes: one request outstanding, answer awaited before the next
// Notes: signals change 1 ns after link_clk rises
`timescale 1ns/1ps
module svid_master_model (
	input wire logic link_clk, // Link clock
	output logic req_valid, // Request pulse
	output logic req_write, // Write flag
	output logic [7:0] req_index, // Register index
	output logic [7:0] req_wdata, // Write data
	input wire logic req_busy, // Request outstanding
	input wire logic rsp_valid, // Answer pulse
	input wire logic [7:0] rsp_rdata, // Answer data
	input wire logic alert_n // Device alert, low active
);
	int timeouts = 0;
	logic busy_seen = 1'b0;

	// Idle levels at time zero
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_index = 8'h00;
		req_wdata = 8'h00;
	end

	// One transfer; stale fields inverted so a late capture shows up
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		rd = 8'hxx;
		@(posedge link_clk);
		#1;
		req_valid = 1'b1;
		req_write = wr;
		req_index = idx;
		req_wdata = wd;
		@(posedge link_clk);
		#1;
		req_valid = 1'b0;
		req_index = ~idx;
		req_wdata = ~wd;
		busy_seen = req_busy;
		for (n = 0; n < 40; n++) begin
			@(posedge link_clk);
			#1;
			if (rsp_valid === 1'b1) begin
				rd = rsp_rdata;
				break;
			end
		end
		if (n == 40) begin
			timeouts++;
		end
	endtask

	task automatic service_alert(output logic [7:0] st);
		int n;
		for (n = 0; n < 20 && alert_n !== 1'b0; n++) begin
			@(posedge link_clk);
		end
		xfer(1'b0, svid_regs_pkg::IDX_PRIMARY_STATUS, 8'h00, st);
	endtask
endmodule

// File: svid_regs_pkg.sv
// Purpose: constants for the serial VID telemetry register bank
// Assumes: one byte per register index, 8-bit data
// Notes: indices are the serial VID register indices
package svid_regs_pkg;
	localparam int DATA_W = 8;

	// --------------------------------------------------------------
	// Register indices
	// --------------------------------------------------------------
	localparam logic [7:0] IDX_DATE_CODE = 8'h03;
	localparam logic [7:0] IDX_PROTOCOL_REVISION = 8'h05;
	localparam logic [7:0] IDX_FEATURE_FLAGS = 8'h06;
	localparam logic [7:0] IDX_PRIMARY_STATUS = 8'h10;
	localparam logic [7:0] IDX_SECONDARY_STATUS = 8'h11;
	localparam logic [7:0] IDX_THERMAL_ZONE = 8'h12;
	localparam logic [7:0] IDX_CURRENT_READING = 8'h15;
	localparam logic [7:0] IDX_VOLTAGE_READING = 8'h16;
	localparam logic [7:0] IDX_TEMPERATURE_READING = 8'h17;
	localparam logic [7:0] IDX_POWER_READING = 8'h18;
	localparam logic [7:0] IDX_SECONDARY_HISTORY = 8'h1c;
	localparam logic [7:0] IDX_CURRENT_LIMIT = 8'h21;
	localparam logic [7:0] IDX_THERMAL_LIMIT = 8'h22;
	localparam logic [7:0] IDX_FAST_RAMP_RATE = 8'h24;
	localparam logic [7:0] IDX_SLOW_RAMP_RATE = 8'h25;
	localparam logic [7:0] IDX_BOOT_VOLTAGE = 8'h26;
	localparam logic [7:0] IDX_SLOW_DIVIDER_SELECT = 8'h2a;
	localparam logic [7:0] IDX_DEEPEST_EXIT_LATENCY = 8'h2b;
	localparam logic [7:0] IDX_STATE_THREE_EXIT_LATENCY = 8'h2c;
	localparam logic [7:0] IDX_ENABLE_TO_COMMAND_LATENCY = 8'h2d;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [7:0] RST_PROTOCOL_REVISION = 8'h01;
	localparam logic [7:0] RST_FEATURE_FLAGS = 8'hd7;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_READING = 8'h01;
	localparam logic [7:0] RST_CURRENT_LIMIT = 8'h00;
	localparam logic [7:0] RST_THERMAL_LIMIT = 8'h64;
	localparam logic [7:0] RST_FAST_RAMP_RATE = 8'h32;
	localparam logic [7:0] RST_SLOW_RAMP_RATE = 8'h0c;
	localparam logic [7:0] RST_BOOT_VOLTAGE = 8'h00;
	localparam logic [1:0] RST_SLOW_DIVIDER_SELECT = 2'h2;
	localparam logic [7:0] RST_LATENCY = 8'h00;
	localparam logic [7:0] RST_DATE_CODE = 8'h00;

	// Smallest reading that still means "supported"
	localparam logic [7:0] MIN_SUPPORTED_READING = 8'h01;
	// Unmapped index read value
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	typedef enum logic {
		LINK_IDLE,
		LINK_WAIT
	} link_state_t;
endpackage

// File: svid_telemetry_register_bank.sv
// Purpose: telemetry, status and limit registers of a single-phase regulator
// Assumes: frame logic on link_clk hands in decoded register requests;
// Assumes: ADC codes and status bits arrive from logic on clk
// Notes: requests cross to clk by toggle handshake, answers cross back
//
// Functional notes
// RL1: feature flags read fixed D7h: current format, temp, output P/V/I supported.
// RL2: current format bit set, so full-scale current code means programmed max current.
// RL3: primary status offered after alert; master reads it on alert.
// RL4: current reading is 8-bit ADC code, all ones at 2 V; resets to 01h.
// RL5: voltage reading is differential remote-sense ADC code, 8 mV per LSB.
// RL6: temperature reads degrees Celsius binary; zero would mean unsupported.
// RL7: power reading is voltage times current; zero would mean unsupported.
// RL8: reading secondary status copies it into the history register.
// RL9: max-current setting sampled once after power-up, then read-only.
// RL10: writable thermal limit, reset 64h, sets overtemperature indicator threshold.
// RL11: read-only fast ramp rate, reset 32h, governs fast voltage-set commands.
// RL12: read-only slow ramp rate, reset 0Ch, quarter of fast rate.
// RL13: slow divider select picks fast/2,/4,/8,/16, default /4, applied to slow ramps.
// RL14: ramp to boot voltage, hold until a voltage-set command; boot reads 00h.
// RL15: report deepest-state exit latency in microseconds.
// RL16: report state-three exit latency in microseconds.
// RL17: report enable-to-command-ready latency in a read-only register.
// RL18: protocol revision register reads 01h.
// RL19: thermal zone register reports current zone, reset 00h.
// RL20: writes to read-only registers ignored; unmapped reads disturb nothing.
// RL21: registers load reset values before command readiness is signalled.
`timescale 1ns/1ps
module svid_telemetry_register_bank #(
	parameter logic [7:0] DATE_CODE = svid_regs_pkg::RST_DATE_CODE, // Arbitrary value
	parameter logic [7:0] BOOT_VOLTAGE = svid_regs_pkg::RST_BOOT_VOLTAGE, // Boot VID code
	parameter logic [7:0] DEEPEST_EXIT_US = svid_regs_pkg::RST_LATENCY, // Microseconds
	parameter logic [7:0] STATE_THREE_EXIT_US = svid_regs_pkg::RST_LATENCY, // Microseconds
	parameter logic [7:0] ENABLE_TO_COMMAND_US = svid_regs_pkg::RST_LATENCY // Microseconds
) (
	input wire logic clk, // Core clock, 100 MHz
	input wire logic rst_n, // Core synchronous reset
	input wire logic link_clk, // Serial interface clock
	input wire logic link_rst_n, // Link synchronous reset
	input wire logic req_valid, // Register request pulse
	input wire logic req_write, // 1 write, 0 read
	input wire logic [7:0] req_index, // Register index
	input wire logic [svid_regs_pkg::DATA_W-1:0] req_wdata, // Write data
	output logic req_busy, // Request outstanding
	output logic rsp_valid, // Answer pulse
	output logic [svid_regs_pkg::DATA_W-1:0] rsp_rdata, // Read data
	input wire logic sample_valid, // ADC codes valid pulse
	input wire logic [7:0] current_sense_input, // Output current code
	input wire logic [7:0] voltage_sense_code, // Remote-sense difference code
	input wire logic [7:0] temperature_code, // Degrees Celsius
	input wire logic [7:0] current_limit_setting_input, // Max-current code
	input wire logic [7:0] primary_status_in, // Regulator condition
	input wire logic [7:0] secondary_status_in, // Optional status
	input wire logic [7:0] thermal_zone_in, // Zone indication
	input wire logic voltage_set_command, // Voltage-set pulse
	output logic alert_n, // Alert, low active
	output logic overtemperature_indicator, // Hot indicator
	output logic [7:0] fast_ramp_value, // Fast slew mV/us
	output logic [7:0] slow_ramp_value, // Slow slew mV/us
	output logic [7:0] boot_target, // Boot VID code
	output logic boot_hold, // Holding at boot voltage
	output logic command_ready // Ready for commands
);
	import svid_regs_pkg::*;

	// --------------------------------------------------------------
	// Link domain: request capture and answer return
	// --------------------------------------------------------------
	link_state_t link_state_reg;
	logic req_tgl_reg;
	logic req_write_reg;
	logic [7:0] req_index_reg;
	logic [7:0] req_wdata_reg;
	logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
	logic ack_tgl_reg;
	logic [7:0] core_rdata_reg;

	// Answer toggle synchroniser into the link domain
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_s3_reg <= 1'b0;
		end else begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_s3_reg <= ack_s2_reg;
		end
	end

	// One request in flight; fields held stable until answered
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			link_state_reg <= LINK_IDLE;
			req_tgl_reg <= 1'b0;
			req_write_reg <= 1'b0;
			req_index_reg <= 8'h00;
			req_wdata_reg <= 8'h00;
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
		end else begin
			rsp_valid <= 1'b0;
			case (link_state_reg)
				LINK_IDLE: begin
					if (req_valid) begin
						req_write_reg <= req_write;
						req_index_reg <= req_index;
						req_wdata_reg <= req_wdata;
						req_tgl_reg <= ~req_tgl_reg;
						link_state_reg <= LINK_WAIT;
					end
				end
				LINK_WAIT: begin
					// Core data is static once its toggle is seen here
					if (ack_s2_reg != ack_s3_reg) begin
						rsp_rdata <= core_rdata_reg;
						rsp_valid <= 1'b1;
						link_state_reg <= LINK_IDLE;
					end
				end
				default: link_state_reg <= LINK_IDLE;
			endcase
		end
	end

	// Requests arriving while busy are dropped
	assign req_busy = (link_state_reg == LINK_WAIT);

	// --------------------------------------------------------------
	// Core domain: request synchroniser
	// --------------------------------------------------------------
	logic req_s1_reg, req_s2_reg, req_s3_reg;
	logic core_go;
	logic core_rd, core_wr;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
		end
	end

	assign core_go = req_s2_reg ^ req_s3_reg;
	assign core_rd = core_go && !req_write_reg;
	assign core_wr = core_go && req_write_reg;

	// Only the thermal limit and divider select take writes
	function automatic logic is_writable(input logic [7:0] idx);
		is_writable = (idx == IDX_THERMAL_LIMIT) || (idx == IDX_SLOW_DIVIDER_SELECT);
	endfunction

	// --------------------------------------------------------------
	// Core domain: registers
	// --------------------------------------------------------------
	logic [7:0] primary_status_reg, secondary_status_reg, thermal_zone_reg;
	logic [7:0] current_reading_reg, voltage_reading_reg;
	logic [7:0] temperature_reading_reg, power_reading_reg;
	logic [7:0] secondary_history_reg;
	logic [7:0] current_limit_reg;
	logic current_limit_loaded_reg;
	logic [7:0] thermal_limit_reg;
	logic [2:0] divider_select_reg;
	logic [15:0] power_product;
	logic [7:0] power_next;
	logic [7:0] temperature_next;
	logic [7:0] read_mux;

	// Status snapshots from the power stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			primary_status_reg <= RST_STATUS;
			secondary_status_reg <= RST_STATUS;
			thermal_zone_reg <= RST_STATUS;
		end else begin
			primary_status_reg <= primary_status_in;
			secondary_status_reg <= secondary_status_in;
			// RL19: zone tracking
			thermal_zone_reg <= thermal_zone_in;
		end
	end

	// RL7: power from voltage times current, upper byte kept
	assign power_product = voltage_reading_reg * current_reading_reg;
	assign power_next = (power_product[15:8] == 8'h00) ? MIN_SUPPORTED_READING
		: power_product[15:8];
	// RL6: zero reserved for unsupported, so clamp
	assign temperature_next = (temperature_code == 8'h00) ? MIN_SUPPORTED_READING
		: temperature_code;

	// Telemetry readings, refreshed on each ADC sample; power on every cycle without one
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			current_reading_reg <= RST_READING;
			voltage_reading_reg <= RST_READING;
			temperature_reading_reg <= RST_READING;
			power_reading_reg <= RST_READING;
		end else if (sample_valid) begin
			// RL2: full scale means max current
			// RL4: raw code, full scale at 2 V sense
			current_reading_reg <= current_sense_input;
			// RL5: 8 mV per LSB code
			voltage_reading_reg <= voltage_sense_code;
			temperature_reading_reg <= temperature_next;
		end else begin
			// Power lags its operands by one cycle
			power_reading_reg <= power_next;
		end
	end

	// RL8: history copy on secondary status read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			secondary_history_reg <= RST_STATUS;
		end else if (core_rd && req_index_reg == IDX_SECONDARY_STATUS) begin
			secondary_history_reg <= secondary_status_reg;
		end
	end

	// RL9: first ADC sample after reset fixes the limit for good
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			current_limit_reg <= RST_CURRENT_LIMIT;
			current_limit_loaded_reg <= 1'b0;
		end else if (sample_valid && !current_limit_loaded_reg) begin
			current_limit_reg <= current_limit_setting_input;
			current_limit_loaded_reg <= 1'b1;
		end
	end

	// RL20: writable registers only; other writes fall through
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			thermal_limit_reg <= RST_THERMAL_LIMIT;
			divider_select_reg <= {1'b0, RST_SLOW_DIVIDER_SELECT};
		end else if (core_wr && is_writable(req_index_reg)) begin
			// RL10: thermal limit write
			if (req_index_reg == IDX_THERMAL_LIMIT) begin
				thermal_limit_reg <= req_wdata_reg;
			end else if (req_wdata_reg >= 8'h01 && req_wdata_reg <= 8'h04) begin
				// RL13: codes 1 to 4 only; others ignored
				divider_select_reg <= req_wdata_reg[2:0];
			end
		end
	end

	// Read mux; unmapped indices read zero and touch nothing
	always_comb begin
		case (req_index_reg)
			IDX_DATE_CODE: read_mux = DATE_CODE;
			// RL18: protocol revision
			IDX_PROTOCOL_REVISION: read_mux = RST_PROTOCOL_REVISION;
			// RL1: fixed feature flags
			IDX_FEATURE_FLAGS: read_mux = RST_FEATURE_FLAGS;
			// RL3: condition for alert service
			IDX_PRIMARY_STATUS: read_mux = primary_status_reg;
			IDX_SECONDARY_STATUS: read_mux = secondary_status_reg;
			IDX_THERMAL_ZONE: read_mux = thermal_zone_reg;
			IDX_CURRENT_READING: read_mux = current_reading_reg;
			IDX_VOLTAGE_READING: read_mux = voltage_reading_reg;
			IDX_TEMPERATURE_READING: read_mux = temperature_reading_reg;
			IDX_POWER_READING: read_mux = power_reading_reg;
			IDX_SECONDARY_HISTORY: read_mux = secondary_history_reg;
			IDX_CURRENT_LIMIT: read_mux = current_limit_reg;
			IDX_THERMAL_LIMIT: read_mux = thermal_limit_reg;
			// RL11: fast rate register
			IDX_FAST_RAMP_RATE: read_mux = RST_FAST_RAMP_RATE;
			// RL12: slow rate follows the selector
			IDX_SLOW_RAMP_RATE: read_mux = slow_ramp_value;
			IDX_BOOT_VOLTAGE: read_mux = BOOT_VOLTAGE;
			IDX_SLOW_DIVIDER_SELECT: read_mux = {5'h00, divider_select_reg};
			// RL15: deepest-state exit latency
			IDX_DEEPEST_EXIT_LATENCY: read_mux = DEEPEST_EXIT_US;
			// RL16: state-three exit latency
			IDX_STATE_THREE_EXIT_LATENCY: read_mux = STATE_THREE_EXIT_US;
			// RL17: enable-to-ready latency
			IDX_ENABLE_TO_COMMAND_LATENCY: read_mux = ENABLE_TO_COMMAND_US;
			default: read_mux = UNMAPPED_READ;
		endcase
	end

	// Answer capture; toggle and data change together
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core_rdata_reg <= 8'h00;
			ack_tgl_reg <= 1'b0;
		end else if (core_go) begin
			core_rdata_reg <= req_write_reg ? 8'h00 : read_mux;
			ack_tgl_reg <= ~ack_tgl_reg;
		end
	end

	// --------------------------------------------------------------
	// Power-stage outputs
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overtemperature_indicator <= 1'b0;
			alert_n <= 1'b1;
			fast_ramp_value <= RST_FAST_RAMP_RATE;
			slow_ramp_value <= RST_SLOW_RAMP_RATE;
			boot_target <= RST_BOOT_VOLTAGE;
			boot_hold <= 1'b1;
			command_ready <= 1'b0;
		end else begin
			// RL10: hot at or above the limit
			overtemperature_indicator <= (temperature_reading_reg >= thermal_limit_reg);
			// RL3: alert while the regulator reports a condition
			alert_n <= (primary_status_reg == 8'h00);
			fast_ramp_value <= RST_FAST_RAMP_RATE;
			// RL13: code n divides the fast rate by two to the n
			slow_ramp_value <= RST_FAST_RAMP_RATE >> divider_select_reg;
			// RL14: boot target held until first voltage-set
			boot_target <= BOOT_VOLTAGE;
			if (voltage_set_command) begin
				boot_hold <= 1'b0;
			end
			// RL21: ready only after the limit has been captured
			command_ready <= current_limit_loaded_reg;
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_FEATURE_READ: assert property ( // RL1
		core_rd && req_index_reg == IDX_FEATURE_FLAGS |=> core_rdata_reg == 8'hd7)
		else $error("feature flags read wrong");
	AST_CURRENT_FULL_SCALE: assert property ( // RL4
		sample_valid && current_sense_input == 8'hff |=> current_reading_reg == 8'hff)
		else $error("full scale current not reported");
	AST_TEMP_NONZERO: assert property ( // RL6
		sample_valid |=> temperature_reading_reg != 8'h00)
		else $error("temperature reads unsupported");
	AST_POWER_PRODUCT: assert property ( // RL7
		!sample_valid ##1 !sample_valid |-> power_reading_reg ==
		(($past(power_product[15:8]) == 8'h00) ? 8'h01 : $past(power_product[15:8])))
		else $error("power reading mismatch");
	AST_HISTORY_COPY: assert property ( // RL8
		core_rd && req_index_reg == IDX_SECONDARY_STATUS
		|=> secondary_history_reg == $past(secondary_status_reg))
		else $error("history not copied");
	AST_LIMIT_FROZEN: assert property ( // RL9
		current_limit_loaded_reg |=> $stable(current_limit_reg))
		else $error("current limit changed after load");
	AST_HOT_THRESHOLD: assert property ( // RL10
		temperature_reading_reg >= thermal_limit_reg |=> overtemperature_indicator)
		else $error("hot indicator missed");
	AST_SLOW_DIVIDE: assert property ( // RL13
		core_wr && req_index_reg == IDX_SLOW_DIVIDER_SELECT && req_wdata_reg == 8'h04
		|=> ##1 slow_ramp_value == 8'h03)
		else $error("slow rate not divided by 16");
	AST_BOOT_HOLD: assert property ( // RL14
		boot_hold && !voltage_set_command |=> boot_hold)
		else $error("boot hold dropped early");
	AST_RO_WRITE: assert property ( // RL20
		core_wr && req_index_reg == IDX_CURRENT_LIMIT |=> $stable(current_limit_reg)
		|| $past(sample_valid && !current_limit_loaded_reg))
		else $error("read-only register written");
	AST_ALERT_STATUS: assert property ( // RL3
		$fell(alert_n) |-> $past(primary_status_reg) != 8'h00)
		else $error("alert without status");
	AST_RESET_VALUES: assert property (@(posedge clk) disable iff (1'b0) // RL21
		!rst_n |=> current_reading_reg == 8'h01 && thermal_limit_reg == 8'h64 && !command_ready)
		else $error("reset values wrong");
	AST_RSP_PULSE: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		rsp_valid |=> !rsp_valid)
		else $error("answer pulse too long");

	COV_READ_HISTORY: cover property (core_rd && req_index_reg == IDX_SECONDARY_STATUS);
	COV_LIMIT_WRITE: cover property (core_wr && req_index_reg == IDX_THERMAL_LIMIT);
	COV_HOT: cover property ($rose(overtemperature_indicator));
	COV_BOOT_LEAVE: cover property ($fell(boot_hold));
endmodule

// File: test_svid_telemetry_register_bank.sv
// Purpose: self-checking bench for the telemetry register bank
// Assumes: master model drives the link side, bench drives the core side
// Notes: two unrelated clocks, 10 ns core and 32 ns link
`timescale 1ns/1ps
module test_svid_telemetry_register_bank;
	import svid_regs_pkg::*;
	logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, link_rst_n = 1'b0;
	logic req_valid, req_write, req_busy, rsp_valid, sample_valid = 1'b0;
	logic [7:0] req_index, req_wdata, rsp_rdata, fast_ramp_value, slow_ramp_value, boot_target;
	logic [7:0] current_sense_input = 8'h00, voltage_sense_code = 8'h00, temperature_code = 8'h00;
	logic [7:0] current_limit_setting_input = 8'h00, primary_status_in = 8'h00;
	logic [7:0] secondary_status_in = 8'h00, thermal_zone_in = 8'h00;
	logic voltage_set_command = 1'b0, alert_n, overtemperature_indicator, boot_hold, command_ready;
	int fails = 0, check_count = 0;
	logic [7:0] idx_tab [21] = '{8'h03, 8'h05, 8'h06, 8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17,
		8'h18, 8'h1c, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h07};
	logic [7:0] rst_tab [21] = '{8'h00, 8'h01, 8'hd7, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
		8'h01, 8'h00, 8'h00, 8'h64, 8'h32, 8'h0c, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

	// Clocks; the even link half period never lands on a rising core edge
	always #5 clk = ~clk;
	always #16 link_clk = ~link_clk;

	svid_telemetry_register_bank uut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
		.link_rst_n(link_rst_n), .req_valid(req_valid), .req_write(req_write),
		.req_index(req_index), .req_wdata(req_wdata), .req_busy(req_busy),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sample_valid(sample_valid),
		.current_sense_input(current_sense_input), .voltage_sense_code(voltage_sense_code),
		.temperature_code(temperature_code),
		.current_limit_setting_input(current_limit_setting_input),
		.primary_status_in(primary_status_in), .secondary_status_in(secondary_status_in),
		.thermal_zone_in(thermal_zone_in), .voltage_set_command(voltage_set_command),
		.alert_n(alert_n), .overtemperature_indicator(overtemperature_indicator),
		.fast_ramp_value(fast_ramp_value), .slow_ramp_value(slow_ramp_value),
		.boot_target(boot_target), .boot_hold(boot_hold), .command_ready(command_ready));

	svid_master_model m (.link_clk(link_clk), .req_valid(req_valid), .req_write(req_write),
		.req_index(req_index), .req_wdata(req_wdata), .req_busy(req_busy),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .alert_n(alert_n));

	// Shared helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic at_clk();
		@(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		m.xfer(1'b0, idx, 8'h00, v);
		check(v, exp);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] v;
		m.xfer(1'b1, idx, d, v);
	endtask

	task automatic sample(input logic [7:0] c, input logic [7:0] v, input logic [7:0] t,
		input logic [7:0] l);
		at_clk();
		sample_valid = 1'b1;
		current_sense_input = c;
		voltage_sense_code = v;
		temperature_code = t;
		current_limit_setting_input = l;
		at_clk();
		sample_valid = 1'b0;
		repeat (4) at_clk();
	endtask

	// Scenarios
	task automatic t_reset();
		for (int i = 0; i < 21; i++) rd(idx_tab[i], rst_tab[i]);
		check(fast_ramp_value, 8'h32);
		check(slow_ramp_value, 8'h0c);
		check({7'h00, command_ready}, 8'h00);
		check({7'h00, m.busy_seen}, 8'h01);
		check({7'h00, req_busy}, 8'h00);
		$display("reset values test done");
	endtask

	task automatic t_adc();
		sample(8'hff, 8'h80, 8'h64, 8'ha5);
		rd(8'h15, 8'hff);
		rd(8'h16, 8'h80);
		rd(8'h17, 8'h64);
		rd(8'h18, 8'h7f);
		rd(8'h21, 8'ha5);
		check({7'h00, command_ready}, 8'h01);
		check({7'h00, overtemperature_indicator}, 8'h01);
		sample(8'h40, 8'h80, 8'h64, 8'h11);
		rd(8'h15, 8'h40);
		rd(8'h18, 8'h20);
		rd(8'h21, 8'ha5);
		$display("adc test done");
	endtask

	task automatic t_writes();
		wr(8'h22, 8'h65);
		rd(8'h22, 8'h65);
		check({7'h00, overtemperature_indicator}, 8'h00);
		sample(8'h40, 8'h80, 8'h00, 8'h11);
		rd(8'h17, 8'h01);
		for (int i = 1; i < 5; i++) begin
			wr(8'h2a, i[7:0]);
			rd(8'h2a, i[7:0]);
			check(slow_ramp_value, 8'h32 >> i);
		end
		wr(8'h2a, 8'h05);
		rd(8'h2a, 8'h04);
		wr(8'h24, 8'hff);
		rd(8'h24, 8'h32);
		wr(8'h06, 8'h00);
		rd(8'h06, 8'hd7);
		wr(8'h21, 8'h00);
		rd(8'h21, 8'ha5);
		rd(8'h07, 8'h00);
		$display("write test done");
	endtask

	task automatic t_status();
		logic [7:0] v;
		at_clk();
		secondary_status_in = 8'h5a;
		thermal_zone_in = 8'h02;
		rd(8'h11, 8'h5a);
		at_clk();
		secondary_status_in = 8'h33;
		rd(8'h1c, 8'h5a);
		rd(8'h12, 8'h02);
		at_clk();
		primary_status_in = 8'h04;
		m.service_alert(v);
		check(v, 8'h04);
		check({7'h00, alert_n}, 8'h00);
		at_clk();
		primary_status_in = 8'h00;
		repeat (4) at_clk();
		check({7'h00, alert_n}, 8'h01);
		$display("status test done");
	endtask

	task automatic t_boot();
		check({7'h00, boot_hold}, 8'h01);
		check(boot_target, 8'h00);
		at_clk();
		voltage_set_command = 1'b1;
		at_clk();
		voltage_set_command = 1'b0;
		repeat (3) at_clk();
		check({7'h00, boot_hold}, 8'h00);
		$display("boot test done");
	endtask

	task automatic wrap_up();
		fails += m.timeouts;
		$display("comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Main sequence: resets, then each scenario
	initial begin
		repeat (4) at_clk();
		rst_n = 1'b1;
		repeat (2) @(posedge link_clk);
		#1;
		link_rst_n = 1'b1;
		t_reset();
		t_adc();
		t_writes();
		t_status();
		t_boot();
		wrap_up();
	end

	// Watchdog, well beyond the expected run of under ten microseconds
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule
